/* File: hdl/dmv_decode.sv */
// Decode and execute logic for the data-move instruction group
`timescale 1ns/1ps
module dmv_decode import dmv_pkg::*; #(
  parameter int unsigned ADDR_W = DMV_AW
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic [DMV_IW-1:0] instr,
  output logic [ADDR_W-1:0] file_raddr,
  input wire logic [DMV_DW-1:0] file_rdata,
  input wire logic zero_in,
  output logic file_we,
  output logic [ADDR_W-1:0] file_waddr,
  output logic [DMV_DW-1:0] file_wdata,
  output logic zero_we,
  output logic zero_out,
  output logic [DMV_DW-1:0] acc,
  output logic illegal
);
  // Widths of the opcode prefixes, derived from the package encodings
  localparam int unsigned LIT_TOP_W = $bits(DMV_LIT_TOP);
  localparam int unsigned MOVE_TOP_W = $bits(DMV_MOVE_TOP);
  localparam int unsigned STORE_TOP_W = $bits(DMV_STORE_TOP);

  // The address field width is fixed by the word layout
  if (ADDR_W != DMV_AW) begin : g_addr_w_check
    $error("dmv_decode: ADDR_W must match the address field of the word");
  end

  // Decoded operation and instruction fields
  dmv_op_t op;
  logic [ADDR_W-1:0] faddr;
  logic [DMV_DW-1:0] literal;
  logic dir_to_file;
  logic rdata_zero;
  logic hit_lit;
  logic hit_move;
  logic hit_store;
  logic hit_idle;

  // Accumulator
  logic [DMV_DW-1:0] acc_r;
  logic [DMV_DW-1:0] acc_nxt;

  // File write port
  logic we_r;
  logic we_nxt;
  logic [ADDR_W-1:0] wa_r;
  logic [ADDR_W-1:0] wa_nxt;
  logic [DMV_DW-1:0] wd_r;
  logic [DMV_DW-1:0] wd_nxt;

  // Zero flag update
  logic zwe_r;
  logic zwe_nxt;
  logic z_r;
  logic z_nxt;

  // Refused word pulse
  logic ill_r;
  logic ill_nxt;

  // Instruction fields
  assign faddr = instr[ADDR_W-1:0];
  assign literal = instr[DMV_DW-1:0];
  assign dir_to_file = instr[DMV_DIR_BIT];
  assign rdata_zero = (file_rdata == '0);

  // Combinational read port, so the value is ready within the word's cycle
  assign file_raddr = faddr;

  // Opcode prefix matches
  always_comb begin
    hit_lit = (instr[DMV_IW-1 -: LIT_TOP_W] == DMV_LIT_TOP);
    hit_move = (instr[DMV_IW-1 -: MOVE_TOP_W] == DMV_MOVE_TOP);
    hit_store = (instr[DMV_IW-1 -: STORE_TOP_W] == DMV_STORE_TOP);
    hit_idle = ((instr & DMV_IDLE_MASK) == DMV_IDLE_CODE);
  end

  // Operation select; the literal don't-care bits are not looked at
  always_comb begin
    op = DMV_OP_NONE;
    if (!instr_valid) begin
      op = DMV_OP_NONE;
    end else if (hit_lit) begin
      op = DMV_OP_LIT;
    end else if (hit_move) begin
      op = DMV_OP_MOVE;
    end else if (hit_store) begin
      op = DMV_OP_STORE;
    end else if (hit_idle) begin
      op = DMV_OP_IDLE;
    end else begin
      op = DMV_OP_NONE;
    end
  end

  // Accumulator next value
  always_comb begin
    acc_nxt = acc_r;
    case (op)
      DMV_OP_LIT: begin
        acc_nxt = literal;
      end
      DMV_OP_MOVE: begin
        if (!dir_to_file) begin
          acc_nxt = file_rdata;
        end
      end
      DMV_OP_IDLE: begin
        acc_nxt = acc_r;
      end
      default: begin
        acc_nxt = acc_r;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_r <= DMV_ACC_RST;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // File write port next values; address and data hold between writes
  always_comb begin
    we_nxt = 1'b0;
    wa_nxt = wa_r;
    wd_nxt = wd_r;
    case (op)
      DMV_OP_MOVE: begin
        if (dir_to_file) begin
          we_nxt = 1'b1;
          wa_nxt = faddr;
          wd_nxt = file_rdata;
        end
      end
      DMV_OP_STORE: begin
        we_nxt = 1'b1;
        wa_nxt = faddr;
        wd_nxt = acc_r;
      end
      DMV_OP_IDLE: begin
        we_nxt = 1'b0;
      end
      default: begin
        we_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      we_r <= 1'b0;
      wa_r <= '0;
      wd_r <= '0;
    end else begin
      we_r <= we_nxt;
      wa_r <= wa_nxt;
      wd_r <= wd_nxt;
    end
  end

  // Zero flag next values; between updates the output follows the status flag
  always_comb begin
    zwe_nxt = 1'b0;
    z_nxt = zero_in;
    case (op)
      DMV_OP_MOVE: begin
        zwe_nxt = 1'b1;
        z_nxt = rdata_zero;
      end
      DMV_OP_IDLE: begin
        zwe_nxt = 1'b0;
      end
      default: begin
        // Literal load and store leave the flag alone
        zwe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      zwe_r <= 1'b0;
      z_r <= 1'b0;
    end else begin
      zwe_r <= zwe_nxt;
      z_r <= z_nxt;
    end
  end

  // A valid word outside the group is flagged and otherwise ignored
  always_comb begin
    ill_nxt = 1'b0;
    if (instr_valid && (op == DMV_OP_NONE)) begin
      ill_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ill_r <= 1'b0;
    end else begin
      ill_r <= ill_nxt;
    end
  end

  // Outputs other than file_raddr come straight from the registers
  assign acc = acc_r;
  assign file_we = we_r;
  assign file_waddr = wa_r;
  assign file_wdata = wd_r;
  assign zero_we = zwe_r;
  assign zero_out = z_r;
  assign illegal = ill_r;
endmodule : dmv_decode

/* File: hdl/dmv_pkg.sv */
// Package with encodings and field layout of the data-move instruction group
package dmv_pkg;
  localparam int unsigned DMV_IW = 14;
  localparam int unsigned DMV_DW = 8;
  localparam int unsigned DMV_AW = 7;
  localparam int unsigned DMV_DIR_BIT = 7;
  localparam logic [5:0] DMV_MOVE_TOP = 6'h08;
  localparam logic [3:0] DMV_LIT_TOP = 4'hC;
  localparam logic [6:0] DMV_STORE_TOP = 7'h01;
  localparam logic [13:0] DMV_IDLE_MASK = 14'h3F9F;
  localparam logic [13:0] DMV_IDLE_CODE = 14'h0000;
  localparam logic [7:0] DMV_ACC_RST = 8'h00;
  typedef enum logic [2:0] {
    DMV_OP_NONE,
    DMV_OP_IDLE,
    DMV_OP_LIT,
    DMV_OP_MOVE,
    DMV_OP_STORE
  } dmv_op_t;
endpackage : dmv_pkg

/* File: tb/dmv_regfile.sv */
// File register model
`timescale 1ns/1ps
module dmv_regfile (
  input wire logic clk,
  input wire logic file_we,
  input wire logic [6:0] file_raddr,
  input wire logic [6:0] file_waddr,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
  assign file_rdata = mem[file_raddr];
  always @(posedge clk) if (file_we) mem[file_waddr] <= file_wdata;
endmodule : dmv_regfile

/* File: tb/dmv_checker.sv */
// Port assertions for the decoder
`timescale 1ns/1ps
module dmv_checker import dmv_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic file_we,
  input wire logic zero_we,
  input wire logic zero_out,
  input wire logic illegal,
  input wire logic [13:0] instr,
  input wire logic [6:0] file_raddr,
  input wire logic [6:0] file_waddr,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] file_wdata,
  input wire logic [7:0] acc
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire mv = instr_valid && instr[13:8] == 6'h08;
  a_lit_load: assert property (instr_valid && instr[13:10] == 4'hC
    |=> acc == $past(instr[7:0]) && !zero_we) else $error("lit");
  a_read_addr: assert property (file_raddr == instr[6:0]) else $error("ra");
  a_move_acc: assert property (mv && !instr[7]
    |=> acc == $past(file_rdata) && !file_we) else $error("m0");
  a_move_back: assert property (mv && instr[7] |=> file_we
    && file_waddr == $past(instr[6:0]) && file_wdata == $past(file_rdata)) else $error("m1");
  a_zero_flag: assert property (mv
    |=> zero_we && zero_out == ($past(file_rdata) == 8'h00)) else $error("z");
  a_store_acc: assert property (instr_valid && instr[13:7] == 7'h01
    |=> file_we && file_wdata == $past(acc) && file_waddr == $past(instr[6:0])
    && !zero_we) else $error("st");
  a_idle_word: assert property (instr_valid && (instr & 14'h3F9F) == 14'h0000
    |=> !file_we && !zero_we && $stable(acc)) else $error("idle");
  a_refused_word: assert property (instr_valid && instr[13:12] == 2'b01
    |=> illegal && !file_we && !zero_we && $stable(acc)) else $error("refused");
  c_wb: cover property (file_we && zero_we);
  c_z: cover property (zero_we && zero_out);
  c_st: cover property (file_we && !zero_we);
  c_ill: cover property (illegal);
endmodule : dmv_checker
bind dmv_decode dmv_checker dmv_checker_i (.clk(clk), .nrst(nrst), .instr_valid(instr_valid),
  .file_we(file_we), .zero_we(zero_we), .zero_out(zero_out), .illegal(illegal), .instr(instr),
  .file_raddr(file_raddr), .file_waddr(file_waddr), .file_rdata(file_rdata),
  .file_wdata(file_wdata), .acc(acc));

/* File: tb/tb_top.sv */
// Random data-move bench
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, nrst = 0, instr_valid = 0, zero_in = 0, file_we, zero_we, zero_out, illegal;
  logic zi = 0, bad = 0;
  logic [13:0] instr = 14'h0000;
  logic [6:0] file_raddr, file_waddr, f, wa = 7'h00;
  logic [7:0] file_rdata, file_wdata, acc, a = 8'h00, w = 8'h00, v;
  logic [7:0] sh [128];
  logic [26:0] q [$];
  wire [26:0] seen = {acc, file_we, file_waddr, file_wdata, zero_we, zero_out, illegal};
  int err_total = 0, checked = 0, seed = 32'h57BA6B7A, cyc = 0, op;
  initial forever #50 clk = ~clk;
  dmv_decode dmv_decode_i (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .zero_in(zero_in), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .zero_we(zero_we), .zero_out(zero_out),
    .acc(acc), .illegal(illegal));
  dmv_regfile dmv_regfile_i (.clk(clk), .file_we(file_we), .file_raddr(file_raddr),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .file_rdata(file_rdata));
  task automatic chk(logic [26:0] s, e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic results;
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // n random words per call, each followed by an idle cycle so a write lands before the next read
  task automatic run(int n);
    repeat (n) begin
      op = {$random(seed)} % 6;
      v = 8'($random(seed));
      f = 7'($random(seed));
      if (f[6]) f = {5'h00, f[1:0]};
      zi = 1'($random(seed));
      bad = 1'b0;
      instr_valid <= 1'b1;
      zero_in <= zi;
      case (op)
        0: begin
          instr <= {4'hC, 2'b00, v};
          a = v;
        end
        1, 2: begin
          instr <= {6'h08, op[1], f};
          v = sh[f];
          if (op[1]) begin
            w = v;
            wa = f;
          end else begin
            a = v;
          end
        end
        3: begin
          instr <= {7'h01, f};
          sh[f] = a;
          w = a;
          wa = f;
        end
        4: instr <= {7'h00, v[1:0], 5'h00};
        default: begin
          instr <= {2'b01, v, f[3:0]};
          bad = 1'b1;
        end
      endcase
      @(posedge clk);
      q.push_back({a, op == 2 || op == 3, wa, w, op == 1 || op == 2,
        (op == 1 || op == 2) ? v == 8'h00 : zi, bad});
      instr_valid <= 1'b0;
      @(posedge clk);
    end
  endtask : run
  always @(negedge clk) begin
    if (q.size()) chk(seen, q.pop_front());
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 1000) begin
      err_total++;
      results;
    end
  end
  initial begin
    for (int i = 0; i < 128; i++) sh[i] = 8'(i * 37);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    run(150);
    // Mid-run reset: outputs return to reset values, file contents stay
    nrst <= 1'b0;
    @(posedge clk);
    a = 8'h00;
    w = 8'h00;
    wa = 7'h00;
    q.push_back(27'h0000000);
    @(posedge clk);
    nrst <= 1'b1;
    run(150);
    @(posedge clk);
    results;
  end
endmodule : tb_top
